// ### hw/smb_pkg.sv
// Shared constants, types and helpers of the thermometer bus slave.
// Assumes one 125 MHz core clock; the bus clock is sampled, not used.
package smb_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 8;       // Core clock period
  localparam int unsigned TREQ_NS         = 1440000; // Clock-low request
  // Least time, rounded up to whole cycles
  localparam int unsigned REQ_CYCLES      =
    (TREQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EE_WRITE_CYCLES = 2000;    // Cell write time

  //////////////////////////////////////////////////////////////////////////
  // Command byte decode
  localparam logic [2:0] CMD_RAM   = 3'h0;  // Top bits for RAM access
  localparam logic [2:0] CMD_EE    = 3'h1;  // Top bits for cell access
  localparam logic [7:0] CMD_FLAGS = 8'hf0; // Read status flags
  localparam logic [7:0] CMD_SLEEP = 8'hff; // Enter low power state

  // RAM word locations
  localparam logic [4:0] OFS_IR_RAW_ONE = 5'h04; // Raw channel one
  localparam logic [4:0] OFS_IR_RAW_TWO = 5'h05; // Raw channel two
  localparam logic [4:0] OFS_AMBIENT    = 5'h06; // Ambient temperature
  localparam logic [4:0] OFS_OBJ_ONE    = 5'h07; // Object temperature 1
  localparam logic [4:0] OFS_OBJ_TWO    = 5'h08; // Object temperature 2

  // Nonvolatile cell that holds the own slave address
  localparam logic [4:0] EE_ADDR_CELL  = 5'h0e;
  localparam logic [6:0] ADDR_RESET    = 7'h5a; // Address until written

  // Flag word bit positions
  localparam int unsigned FLAG_BUSY_BIT  = 7;
  localparam int unsigned FLAG_FATAL_BIT = 5;
  localparam int unsigned FLAG_INIT_BIT  = 4;

  //////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic        we;    // Write strobe from measurement core
    logic [4:0]  addr;  // Word location
    logic [16:0] data;  // Word value
  } smb_ram_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // Bus free, or PWM mode or sleep
    ST_RX   = 2'b01,  // Receiving bytes from master
    ST_TX   = 2'b10,  // Sending bytes to master
    ST_WAIT = 2'b11   // Silent until stop or next start
  } smb_state_t;

  //////////////////////////////////////////////////////////////////////////
  // Writable cell check
  function automatic logic smb_ee_writable(input logic [4:0] a);
    return (a <= 5'h05) || (a == 5'h0e) || (a == 5'h0f) || (a == 5'h19);
  endfunction : smb_ee_writable

  // CRC-8, polynomial x8+x2+x1+1, one byte MSB first
  function automatic logic [7:0] smb_crc8(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    logic       fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[7] ^ d[i];
      r  = {r[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    end
    return r;
  endfunction : smb_crc8

endpackage : smb_pkg

// ### hw/smb_mem.sv
// Small word memory with one write port and a registered read port.
// Assumes a single clock; contents are undefined until written.
`timescale 1ns/1ps
module smb_mem #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 32
) (
  // Clock
  input  wire logic                     core_clk_i,
  // Write port
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic      [WIDTH-1:0]         rd_data_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];  // Storage array

  // Write and registered read
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
  end

endmodule : smb_mem

// ### hw/smb_thermo_slave.sv
// Two-wire bus slave of the thermometer: word reads and word writes.
// Assumes bus pins are asynchronous and the wire level is resolved
// outside from the open-drain enable.
`timescale 1ns/1ps
// Summary of operation
// RULE1: RAM words are read only from bus
// RULE2: Raw channels sit at words four, five
// RULE3: Bus clock pin is input only
// RULE4: Data pin open drain in bus mode
// RULE5: Slave only, never drives clock
// RULE6: Writes accepted for nine cells only
// RULE7: Read answered only for own address; code also answers address zero in a frame opened with zero
// RULE8: Address zero with write always answered
// RULE9: Seven bit slave address field
// RULE10: Master avoids duplicate addresses on bus
// RULE11: Sleep command honoured in 3V variant
// RULE12: Busy and fatal flags are readable
// RULE13: Only read word and write word
// RULE14: PWM strap owns pin until request
// RULE15: Direction bit one reads, zero writes
// RULE16: Acknowledge low, refusal high
// RULE17: Acknowledge each byte; address only if ours
// RULE18: Master retries after any refusal
// RULE19: Bad check code refused
// RULE20: Check code skips start, stop, acknowledge
// RULE21: Check code is CRC-8 x8+x2+x+1
// RULE22: Bytes shift MSB first
// RULE23: Command top bits pick RAM or cells
// RULE24: Master erases cell before writing
// RULE25: Read: addr, cmd, restart, addr, three bytes
// RULE26: Write: addr, cmd, two data, check code
module smb_thermo_slave #(
  parameter bit          VARIANT_3V = 1'b1,  // Sleep allowed
  parameter bit          AUTOMOTIVE = 1'b1,  // Fatal flag present
  parameter int unsigned REQ_CYC    = smb_pkg::REQ_CYCLES,
  parameter int unsigned EE_WR_CYC  = smb_pkg::EE_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 arst_n_i,
  // Bus pins
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  // Measurement core side
  input  wire smb_pkg::smb_ram_wr_t ram_wr_i,
  input  wire logic                 pwm_strap_i,
  input  wire logic                 ee_fault_i,
  output logic                      pwm_mode_o,
  output logic                      sleep_o
);
  import smb_pkg::*;

  localparam int unsigned RW = $clog2(REQ_CYC + 1);
  localparam int unsigned BW = $clog2(EE_WR_CYC + 1);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [2:0] scl_s_r;      // Clock pin stages
  logic [2:0] sda_s_r;      // Data pin stages
  logic       scl_f_r;      // Accepted clock level
  logic       sda_f_r;      // Accepted data level
  logic       scl_d_r;      // Previous clock level
  logic       sda_d_r;      // Previous data level

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_i};  // see RULE3
      sda_s_r <= {sda_s_r[1:0], sda_i};
      if (scl_s_r[1] == scl_s_r[2]) begin
        scl_f_r <= scl_s_r[2];
      end
      if (sda_s_r[1] == sda_s_r[2]) begin
        sda_f_r <= sda_s_r[2];
      end
      scl_d_r <= scl_f_r;
      sda_d_r <= sda_f_r;
    end
  end

  wire scl_rise = scl_f_r & ~scl_d_r;
  wire scl_fall = ~scl_f_r & scl_d_r;
  wire start_ev = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
  wire stop_ev  = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;

  //////////////////////////////////////////////////////////////////////////
  // Protocol state
  smb_state_t  state_r;         // Protocol state
  logic [3:0]  bit_cnt_r;       // Clock rises in this byte
  logic [2:0]  byte_idx_r;      // Byte within segment
  logic [1:0]  tx_idx_r;        // Byte being sent
  logic [7:0]  shift_r;         // Received bits
  logic [7:0]  tx_r;            // Bits left to send
  logic [7:0]  crc_r;           // Running check code
  logic [7:0]  cmd_r;           // Command byte
  logic [7:0]  dlo_r;           // Write data low
  logic [7:0]  dhi_r;           // Write data high
  logic        seg2_r;          // After repeated start
  logic        in_frame_r;      // Between start and stop
  logic        zero_ok_r;       // Frame opened with address zero
  logic        ack_r;           // Byte accepted
  logic        go_tx_r;         // Send after acknowledge
  logic        mnack_r;         // Master refused last byte
  logic        drive_r;         // Pulling data low
  logic [6:0]  target_slave_address;  // Own address
  logic [BW-1:0] busy_cnt_r;    // Cell write in progress
  logic [RW-1:0] req_cnt_r;     // Clock low time in PWM mode
  logic        pwm_mode_r;      // Pin owned by PWM
  logic        strap_done_r;    // Strap caught
  logic        sleep_r;         // Low power state
  logic        fatal_r;         // Sampled cell failure
  logic [16:0] ram_rd;          // RAM read word
  logic [15:0] ee_rd;           // Cell read word

  //////////////////////////////////////////////////////////////////////////
  // Byte decode
  wire        bus_en   = ~pwm_mode_r & ~sleep_r;
  wire        fall_ack = scl_fall && bit_cnt_r == 4'h8;
  wire        fall_end = scl_fall && bit_cnt_r == 4'h9;
  wire        rx_ack   = fall_ack && state_r == ST_RX && bus_en;
  wire [6:0]  rx_addr  = shift_r[7:1];
  wire        direction_bit = shift_r[0];  // 1 read, 0 write, see RULE15
  wire        own_hit  = rx_addr == target_slave_address;
  wire        wr_hit   = ~direction_bit &
                         (own_hit | (rx_addr == 7'h00));  // see RULE8
  wire        rd_hit   = direction_bit &
                         (own_hit | (rx_addr == 7'h00 & zero_ok_r));
  wire        sleep_cmd = cmd_r == CMD_SLEEP;
  wire        cmd_ok   = shift_r[7:5] == CMD_RAM ||
                         shift_r[7:5] == CMD_EE ||
                         shift_r == CMD_FLAGS ||
                         shift_r == CMD_SLEEP;            // see RULE13
  wire        pec_ok   = crc_r == shift_r;                // see RULE19
  wire        is_i0    = byte_idx_r == 3'h0;
  wire        is_i1    = byte_idx_r == 3'h1;
  wire        is_i2    = byte_idx_r == 3'h2;
  wire        is_i3    = byte_idx_r == 3'h3;
  wire        is_i4    = byte_idx_r == 3'h4;
  // Accept decision per byte position, see RULE17 and RULE26
  wire        ack_w    = seg2_r ? (is_i0 & rd_hit) :
                         is_i0 ? wr_hit :
                         is_i1 ? cmd_ok :
                         is_i2 ? (sleep_cmd ? pec_ok : 1'b1) :
                         is_i3 ? ~sleep_cmd :
                         is_i4 ? (~sleep_cmd & pec_ok) : 1'b0;
  wire        pec_byte = ~seg2_r & ((is_i2 & sleep_cmd) | is_i4);
  wire        nonvolatile_busy_flag  = busy_cnt_r != '0;
  wire        nonvolatile_fatal_flag = AUTOMOTIVE & fatal_r;
  // RAM writes are dropped; only listed cells, when idle, see RULE1
  wire        ee_we    = rx_ack && is_i4 && ~seg2_r && pec_ok &&
                         cmd_r[7:5] == CMD_EE && ~nonvolatile_busy_flag &&
                         smb_ee_writable(cmd_r[4:0]);  // see RULE6
  // Sleep starts once the acknowledge slot is over, so the master
  // still sees the accepted check code before the pin goes quiet
  wire        sleep_set = fall_end && state_r == ST_RX && ack_r &&
                          bus_en && ~seg2_r && is_i2 && sleep_cmd &&
                          VARIANT_3V;                  // see RULE11

  //////////////////////////////////////////////////////////////////////////
  // Answer word selection
  logic [15:0] flags_w;
  always_comb begin
    flags_w                 = 16'h0000;
    flags_w[FLAG_BUSY_BIT]  = nonvolatile_busy_flag;   // see RULE12
    flags_w[FLAG_FATAL_BIT] = nonvolatile_fatal_flag;
    flags_w[FLAG_INIT_BIT]  = 1'b1;
  end
  wire [15:0] word_w   = (cmd_r == CMD_FLAGS) ? flags_w :
                         (cmd_r[7:5] == CMD_RAM) ? ram_rd[16:1] : ee_rd;
  wire [1:0]  load_idx = (state_r == ST_TX) ? tx_idx_r + 2'h1 : 2'h0;
  wire [7:0]  tx_byte  = (load_idx == 2'h0) ? word_w[7:0] :
                         (load_idx == 2'h1) ? word_w[15:8] : crc_r;

  //////////////////////////////////////////////////////////////////////////
  // Protocol engine
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      byte_idx_r <= 3'h0;
      tx_idx_r   <= 2'h0;
      shift_r    <= 8'h00;
      tx_r       <= 8'h00;
      crc_r      <= 8'h00;
      cmd_r      <= 8'h00;
      dlo_r      <= 8'h00;
      dhi_r      <= 8'h00;
      seg2_r     <= 1'b0;
      in_frame_r <= 1'b0;
      zero_ok_r  <= 1'b0;
      ack_r      <= 1'b0;
      go_tx_r    <= 1'b0;
      mnack_r    <= 1'b0;
      drive_r    <= 1'b0;
    end else if (!bus_en || stop_ev) begin
      // Bus released: idle and silent
      state_r    <= ST_IDLE;
      in_frame_r <= 1'b0;
      drive_r    <= 1'b0;
    end else if (start_ev) begin
      // Start or repeated start; code runs on across a restart
      state_r    <= ST_RX;
      bit_cnt_r  <= 4'h0;
      byte_idx_r <= 3'h0;
      drive_r    <= 1'b0;
      in_frame_r <= 1'b1;
      seg2_r     <= in_frame_r;
      if (!in_frame_r) begin
        crc_r <= 8'h00;                                 // see RULE20
      end
    end else if (state_r == ST_RX || state_r == ST_TX) begin
      if (scl_rise && bit_cnt_r != 4'h9) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r < 4'h8) begin
          shift_r <= {shift_r[6:0], sda_f_r};           // see RULE22
        end
        if (bit_cnt_r == 4'h8) begin
          mnack_r <= sda_f_r;                           // see RULE16
        end
      end
      if (rx_ack) begin
        // Decide and drive the acknowledge slot
        ack_r   <= ack_w;
        go_tx_r <= seg2_r & is_i0;                      // see RULE25
        drive_r <= ack_w;                               // see RULE17
        if (!pec_byte) begin
          crc_r <= smb_crc8(crc_r, shift_r);            // see RULE21
        end
        if (~seg2_r & is_i0) begin
          zero_ok_r <= rx_addr == 7'h00;
        end
        if (~seg2_r & is_i1) begin
          cmd_r <= shift_r;                             // see RULE23
        end
        if (~seg2_r & is_i2) begin
          dlo_r <= shift_r;                             // see RULE26
        end
        if (~seg2_r & is_i3) begin
          dhi_r <= shift_r;
        end
      end
      if (fall_ack && state_r == ST_TX) begin
        drive_r <= 1'b0;  // Release for the master acknowledge
      end
      if (scl_fall && state_r == ST_TX &&
          bit_cnt_r != 4'h0 && bit_cnt_r < 4'h8) begin
        tx_r    <= {tx_r[6:0], 1'b0};
        drive_r <= ~tx_r[6];
      end
      if (fall_end) begin
        bit_cnt_r  <= 4'h0;
        byte_idx_r <= byte_idx_r + 3'h1;
        drive_r    <= 1'b0;
        if ((state_r == ST_RX && !ack_r) ||
            (state_r == ST_TX && (mnack_r || tx_idx_r == 2'h2))) begin
          state_r <= ST_WAIT;                           // see RULE7
        end else if (state_r == ST_TX || go_tx_r) begin
          state_r  <= ST_TX;
          tx_idx_r <= load_idx;
          tx_r     <= tx_byte;
          drive_r  <= ~tx_byte[7];
          if (load_idx != 2'h2) begin
            crc_r <= smb_crc8(crc_r, tx_byte);
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Own address, busy timer, fault sample
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      target_slave_address <= ADDR_RESET;
      busy_cnt_r           <= '0;
      fatal_r              <= 1'b0;
    end else begin
      fatal_r <= ee_fault_i;
      if (ee_we && cmd_r[4:0] == EE_ADDR_CELL) begin
        target_slave_address <= dlo_r[6:0];             // see RULE9
      end
      if (ee_we) begin
        busy_cnt_r <= BW'(EE_WR_CYC);                   // see RULE12
      end else if (nonvolatile_busy_flag) begin
        busy_cnt_r <= busy_cnt_r - BW'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // PWM ownership and sleep; strap caught after reset release
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwm_mode_r   <= 1'b0;
      strap_done_r <= 1'b0;
      req_cnt_r    <= '0;
      sleep_r      <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
      if (!strap_done_r) begin
        pwm_mode_r <= pwm_strap_i;                      // see RULE14
      end else if (pwm_mode_r) begin
        // Long clock low hands the pin back to the bus
        if (scl_f_r) begin
          req_cnt_r <= '0;
        end else if (req_cnt_r == RW'(REQ_CYC - 1)) begin
          pwm_mode_r <= 1'b0;                           // see RULE14
        end else begin
          req_cnt_r <= req_cnt_r + RW'(1);
        end
      end
      if (sleep_set) begin
        sleep_r <= 1'b1;  // Left only by the asynchronous reset arst_n_i
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Memories and outputs
  smb_mem #(.WIDTH(17), .DEPTH(32)) u_ram (
    .core_clk_i (core_clk_i),
    .wr_en_i    (ram_wr_i.we),  // Core side only, see RULE2
    .wr_addr_i  (ram_wr_i.addr),
    .wr_data_i  (ram_wr_i.data),
    .rd_addr_i  (cmd_r[4:0]),
    .rd_data_o  (ram_rd)
  );

  smb_mem #(.WIDTH(16), .DEPTH(32)) u_cells (
    .core_clk_i (core_clk_i),
    .wr_en_i    (ee_we),
    .wr_addr_i  (cmd_r[4:0]),
    .wr_data_i  ({dhi_r, dlo_r}),
    .rd_addr_i  (cmd_r[4:0]),
    .rd_data_o  (ee_rd)
  );

  assign sda_o      = 1'b0;     // Only ever pulls low, see RULE4
  assign sda_oe_o   = drive_r;  // No clock output exists, see RULE5
  assign pwm_mode_o = pwm_mode_r;
  assign sleep_o    = sleep_r;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_OPEN_DRAIN: assert property (sda_oe_o |-> sda_o == 1'b0 && !pwm_mode_o) // see RULE4
    else $error("data pin driven high or in PWM mode");
  AST_IDLE_QUIET: assert property (state_r == ST_IDLE |=> !sda_oe_o) // see RULE5
    else $error("pin driven while idle");
  AST_CELL_LIST: assert property ( // see RULE6
    ee_we |-> cmd_r[7:5] == CMD_EE && (cmd_r[4:0] inside
      {[5'h00:5'h05], 5'h0e, 5'h0f, 5'h19}))
    else $error("write to protected cell");
  AST_BUSY_SET: assert property (ee_we |=> nonvolatile_busy_flag ##1 nonvolatile_busy_flag) // see RULE12
    else $error("busy flag not raised");
  AST_ADDR_SILENT: assert property (rx_ack && is_i0 && !seg2_r && !wr_hit |=> !sda_oe_o) // see RULE17
    else $error("acknowledged a foreign address");
  AST_ACK_LOW: assert property (rx_ack && ack_w |=> sda_oe_o) // see RULE16
    else $error("accepted byte not acknowledged");
  AST_CMD_REFUSE: assert property (rx_ack && is_i1 && !seg2_r && !cmd_ok |=> !sda_oe_o) // see RULE13
    else $error("unsupported command acknowledged");
  AST_BAD_PEC: assert property (rx_ack && pec_byte && !pec_ok |-> !ee_we ##1 !sda_oe_o) // see RULE19
    else $error("bad check code accepted");
  AST_TX_READ: assert property ($rose(state_r == ST_TX) |-> seg2_r && $past(go_tx_r)) // see RULE7
    else $error("sending outside a read");
  AST_SLEEP_3V: assert property ( // see RULE11
    sleep_o |-> VARIANT_3V && !sda_oe_o)
    else $error("sleep on wrong variant or pin driven");

  COV_READ: cover property (fall_end && state_r == ST_TX && tx_idx_r == 2'h2);
  COV_WRITE: cover property (ee_we);
  COV_SLEEP: cover property (sleep_set);
  COV_PWM_EXIT: cover property ($fell(pwm_mode_r));

endmodule : smb_thermo_slave

// ### testbench/smb_master_model.sv
// Bus master model: drives the bus clock, pulls the data wire low.
// Assumes a pull-up outside resolves the data wire from all enables.
`timescale 1ns/1ps
module smb_master_model (
  // Bus pins
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  // Bus idle: clock high, data released
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end
  // One bit: data moves mid low phase, sampled late in high phase
  task automatic bit_x(input logic b, output logic r);
    #40 sda_oe_o <= !b;
    #22.5 scl_o <= 1'b1;
    #60 r = sda_i;
    #2.5 scl_o <= 1'b0;
  endtask : bit_x
  // Byte then acknowledge bit; a released wire reads as ones
  task automatic byte_x(input logic [7:0] d, input logic a,
                        output logic [7:0] q, output logic ar);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(a, ar);
  endtask : byte_x
  // Start or repeated start; clock left low
  task automatic start;
    #40 sda_oe_o <= 1'b0;
    #22.5 scl_o <= 1'b1;
    #60 sda_oe_o <= 1'b1;
    #62.5 scl_o <= 1'b0;
  endtask : start
  // Stop leaves the bus idle, clock still outside frames
  task automatic stop;
    #40 sda_oe_o <= 1'b1;
    #22.5 scl_o <= 1'b1;
    #60 sda_oe_o <= 1'b0;
    #60;
  endtask : stop
  // Clock held low for a while, the request that leaves PWM mode
  task automatic hold_low(input int ns);
    #40 scl_o <= 1'b0;
    #(ns) scl_o <= 1'b1;
    #60;
  endtask : hold_low
endmodule : smb_master_model

// ### testbench/smb_thermo_slave_tb.sv
// Self-checking bench of the thermometer bus slave.
// Assumes design files compile first; the data wire has a pull-up.
`timescale 1ns/1ps
module smb_thermo_slave_tb;
  import smb_pkg::*;
  localparam int unsigned REQ = 50; // Short clock-low request
  logic        core_clk_i  = 1'b0;
  logic        arst_n_i    = 1'b0;
  logic        strap       = 1'b0;
  logic        fault       = 1'b0;
  smb_ram_wr_t ram_wr      = '0;
  logic        scl, m_oe, d_oe, d_o, pwm, slp;
  logic [4:0]  nk;
  int          err_total   = 0;
  int          check_count = 0;
  wire         sda = !m_oe & (!d_oe | d_o); // Open drain, pulled up
  // Lone slave on the bus; clock pin is input only
  smb_thermo_slave #(.REQ_CYC(REQ)) dut (.core_clk_i, .arst_n_i,
    .scl_i(scl), .sda_i(sda), .sda_o(d_o), .sda_oe_o(d_oe), .ram_wr_i(ram_wr),
    .pwm_strap_i(strap), .ee_fault_i(fault), .pwm_mode_o(pwm),
    .sleep_o(slp));
  smb_master_model m (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [16:0] rv(input int i); // RAM test word
    return 17'(32'h1a5c3 + i * 32'h2b07);
  endfunction : rv
  function automatic logic [7:0] crc(input logic [7:0] c, d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction : crc
  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wt; // Outlast the cell write time
    repeat (2100) @(posedge core_clk_i);
  endtask : wt
  // Write frame: n bytes then check code; bad flips its low bit
  task automatic wr(input logic [6:0] a, input logic [7:0] c,
    input logic [15:0] w, input int n, input logic bad, output logic [4:0] k);
    logic [7:0] b [5];
    logic [7:0] p, q;
    logic       ar;
    b = '{{a, 1'b0}, c, w[7:0], w[15:8], 8'h00};
    p = 8'h00;
    k = '0;
    m.start();
    for (int i = 0; i <= n; i++) begin
      if (i == n) b[i] = p ^ {7'h0, bad};
      else p = crc(p, b[i]);
      m.byte_x(b[i], 1'b1, q, ar);
      k[i] = ar;
      if (ar) break;
    end
    m.stop();
  endtask : wr
  // Read frame with restart; checks acks, word and check code
  task automatic rd(input logic [6:0] a, input logic [7:0] c,
                    input logic [2:0] ek, input logic [15:0] ew);
    logic [7:0] q [3];
    logic [7:0] p, x;
    logic [2:0] k;
    logic       ar;
    k = '0;
    m.start();
    m.byte_x({a, 1'b0}, 1'b1, x, k[0]);
    if (!k[0]) m.byte_x(c, 1'b1, x, k[1]);
    if (k == 3'b000) begin
      m.start();
      m.byte_x({a, 1'b1}, 1'b1, x, k[2]);
    end
    if (k == 3'b000) begin
      for (int i = 0; i < 3; i++) m.byte_x(8'hff, i == 2, q[i], ar);
    end
    m.stop();
    chk("ack", {13'h0, ek}, {13'h0, k});
    if (ek == 3'b000) begin
      p = crc(crc(crc(crc(crc(8'h00, {a, 1'b0}), c), {a, 1'b1}), ew[7:0]),
              ew[15:8]);
      chk("data", ew, {q[1], q[0]});
      chk("pec", {8'h0, p}, {8'h0, q[2]});
    end
  endtask : rd
  task automatic test_done;
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    repeat (10) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (12) @(posedge core_clk_i);
    chk("idle", 16'h0, {13'h0, d_oe, pwm, slp});
    for (int i = 0; i < 5; i++) begin // Core loads words four to eight
      ram_wr <= '{1'b1, OFS_IR_RAW_ONE + 5'(i), rv(i)};
      @(posedge core_clk_i);
    end
    ram_wr <= '0;
    for (int i = 0; i < 5; i++) begin
      rd(ADDR_RESET, {CMD_RAM, OFS_IR_RAW_ONE + 5'(i)}, 3'b0, 16'(rv(i) >> 1));
    end
    wr(ADDR_RESET, {CMD_RAM, OFS_IR_RAW_ONE}, 16'h1234, 4, 1'b0, nk);
    chk("ack", 16'h0, {11'h0, nk});
    rd(ADDR_RESET, {CMD_RAM, OFS_IR_RAW_ONE}, 3'b0, 16'(rv(0) >> 1));
    rd(7'h33, {CMD_RAM, OFS_AMBIENT}, 3'b001, 16'h0);
    wr(ADDR_RESET, 8'h80, 16'h0, 4, 1'b0, nk);
    chk("ack", 16'h0002, {11'h0, nk});
    wr(7'h00, 8'h20, 16'h0000, 4, 1'b0, nk);
    chk("ack", 16'h0, {11'h0, nk});
    wt();
    wr(ADDR_RESET, 8'h20, 16'hbeef, 4, 1'b0, nk);
    chk("ack", 16'h0, {11'h0, nk});
    rd(ADDR_RESET, CMD_FLAGS, 3'b0, 16'h0090);
    wr(ADDR_RESET, 8'h20, 16'h1111, 4, 1'b0, nk); // Dropped
    chk("ack", 16'h0, {11'h0, nk});
    wt();
    fault <= 1'b1;
    wr(ADDR_RESET, 8'h20, 16'h0000, 4, 1'b1, nk);
    chk("ack", 16'h0010, {11'h0, nk});
    wt();
    rd(7'h00, 8'h20, 3'b0, 16'hbeef);
    rd(ADDR_RESET, CMD_FLAGS, 3'b0, 16'h0030);
    wr(ADDR_RESET, 8'h2e, 16'h0000, 4, 1'b0, nk);
    wt();
    wr(7'h00, 8'h2e, 16'h0033, 4, 1'b0, nk);
    chk("ack", 16'h0, {11'h0, nk});
    rd(ADDR_RESET, {CMD_RAM, OFS_AMBIENT}, 3'b001, 16'h0);
    rd(7'h33, {CMD_RAM, OFS_AMBIENT}, 3'b0, 16'(rv(2) >> 1));
    wr(7'h33, CMD_SLEEP, 16'h0, 2, 1'b0, nk);
    chk("sleep", 16'h0001, {10'h0, nk, slp});
    @(posedge core_clk_i);
    arst_n_i <= 1'b0; // Second reset with the PWM strap set
    strap    <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (12) @(posedge core_clk_i);
    chk("pwm", 16'h0001, {14'h0, slp, pwm});
    rd(ADDR_RESET, {CMD_RAM, OFS_AMBIENT}, 3'b001, 16'h0);
    m.hold_low(REQ * 16);
    chk("pwm", 16'h0, {15'h0, pwm});
    rd(ADDR_RESET, {CMD_RAM, OFS_AMBIENT}, 3'b0, 16'(rv(2) >> 1));
    test_done();
  end
  // Watchdog well past the expected run length
  initial begin
    #400000;
    err_total++;
    test_done();
  end
endmodule : smb_thermo_slave_tb
